// file: core/rcb_count_block.sv
`timescale 1ns/10ps
// calendar counting block: registers, counters, alarm, rewrite and read control
// What this block does
// [R1] soft reset bit clears block control logic
// [R2] counts seconds through two-digit year
// [R3] february leap days, year 00 leap
// [R4] alarm matches any enabled field set
// [R5] enabled alarm fields compared, flag on match
// [R6] timer period up to one day, single/repeat
// [R7] eight event flags plus half-second pulse
// [R8] reload value loaded at start and zero
// [R9] two divide-by-two prescaler paths
// [R10] timer loads period, counts half-second ticks
// [R11] half-second pairs make the one-second tick
// [R12] software sets calendar while stopped, then starts
// [R13] start copies registers into counters, prescalers
// [R14] counters survive soft reset; read then start continues
// [R15] software polls read request before setting
// [R16] read request copies counters into registers
// [R17] copy done clears request, sets flag
// [R18] no rewrite or soft reset during read
// [R19] no stop until read completion flag
// [R20] rewrite under one second keeps time
// [R21] rewrite halts seconds, transfers written fields
// [R22] overlong rewrite sets error, cleared on exit
// [R23] source clock pin synchronised before use
// [R24] standard calendar rollover limits
module rcb_count_block
   import rcb_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              rtc_source_clock,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rdata,
   output logic [NUM_FLAGS-1:0]   int_flags,
   output logic                   half_sec_pulse,
   output logic                   running
);
   logic                 rstn_q1;
   logic                 rst_n;
   logic                 src_q1;
   logic                 src_q2;
   logic                 src_q3;
   logic                 src_rise;
   logic [SUBSEC_W-1:0]  subsecond_reload_reg;
   logic [PERIOD_W-1:0]  timer_period_reg;
   logic [CAL_W-1:0]     cal_reg [NUM_CAL];
   logic [CAL_W-1:0]     cal_cnt [NUM_CAL];
   logic [CAL_W-1:0]     next_cnt [NUM_CAL];
   logic [CAL_W-1:0]     alm_reg [NUM_ALM];
   logic [NUM_ALM-1:0]   alm_en;
   logic [NUM_ALM-1:0]   alm_hit;
   logic [NUM_ALM-1:0]   alm_eq;
   logic [NUM_CAL-1:0]   cal_hit;
   logic [NUM_CAL-1:0]   cal_dirty;
   logic                 ctrl_wr;
   logic                 flags_wr;
   logic                 counter_read_request;
   logic                 rewrite_continue_bit;
   logic                 block_soft_reset_bit;
   logic                 busy;
   logic                 tm_start;
   logic                 tm_repeat;
   logic                 tm_active;
   logic                 tm_expire;
   logic                 start_load;
   logic                 rw_set;
   logic                 rw_xfer;
   logic                 cal_half;
   logic                 tm_half;
   logic                 half_q;
   logic                 one_sec;
   logic                 pend_sec;
   logic                 sec_tick;
   logic                 alarm_match;
   logic                 alarm_q;
   logic                 c_min;
   logic                 c_hour;
   logic                 c_day;
   logic                 c_mon;
   logic                 c_year;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clr;
   logic [DATA_W-1:0]    ctrl_rd;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstn_q1 <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rstn_q1 <= 1'b1;
         rst_n   <= rstn_q1;
      end
   end

   // the source clock must be slower than half of clk to be seen edge by edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_q1 <= 1'b0;
         src_q2 <= 1'b0;
         src_q3 <= 1'b0;
      end else begin
         src_q1 <= rtc_source_clock;             // [R23]
         src_q2 <= src_q1;
         src_q3 <= src_q2;
      end
   end
   assign src_rise = src_q2 & ~src_q3;

   assign ctrl_wr  = wr_en && (addr == OFS_CTRL);
   assign flags_wr = wr_en && (addr == OFS_FLAGS);

   genvar g;
   generate
      for (g = 0; g < NUM_CAL; g++) begin : g_cal
         assign cal_hit[g] = (addr == OFS_CAL_BASE + 8'(g * 4));
      end
      for (g = 0; g < NUM_ALM; g++) begin : g_alm
         assign alm_hit[g] = (addr == OFS_ALM_BASE + 8'(g * 4));
         assign alm_eq[g]  = ~alm_en[g] | (alm_reg[g] == cal_cnt[g + 1]);   // [R5]
      end
   endgenerate

   assign start_load = ctrl_wr && wdata[CB_START] && !running;                 // [R13]
   assign rw_set     = ctrl_wr && wdata[CB_REWR] && !rewrite_continue_bit
                       && running && !busy;                                    // [R21]
   assign rw_xfer    = ctrl_wr && !wdata[CB_REWR] && rewrite_continue_bit;     // [R21]

   // control bits; soft reset is a one-cycle self-clearing strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         running              <= 1'b0;
         counter_read_request <= 1'b0;
         rewrite_continue_bit <= 1'b0;
         busy                 <= 1'b0;
         tm_start             <= 1'b0;
         tm_repeat            <= 1'b0;
         block_soft_reset_bit <= 1'b0;
      end else if (block_soft_reset_bit) begin
         running              <= 1'b0;                                        // [R1]
         counter_read_request <= 1'b0;
         rewrite_continue_bit <= 1'b0;
         busy                 <= 1'b0;
         tm_start             <= 1'b0;
         tm_repeat            <= 1'b0;
         block_soft_reset_bit <= 1'b0;
      end else begin
         block_soft_reset_bit <= ctrl_wr && wdata[CB_BLOCK_SOFT_RESET_BIT];                   // [R1]
         counter_read_request <= ctrl_wr && wdata[CB_READ]
                                 && !counter_read_request;                     // [R16] [R17]
         if (ctrl_wr) begin
            running   <= wdata[CB_START];
            tm_repeat <= wdata[CB_TMREP];
            tm_start  <= wdata[CB_TMST];
         end else if (tm_expire && !tm_repeat) begin
            tm_start <= 1'b0;
         end
         if (rw_set) begin
            rewrite_continue_bit <= 1'b1;
            busy                 <= 1'b1;                                      // [R21]
         end else if (rw_xfer) begin
            rewrite_continue_bit <= 1'b0;
            busy                 <= 1'b0;                                      // [R21]
         end
      end
   end

   rcb_subsec #(.W(SUBSEC_W)) u_cal_pre (
      .clk       (clk),
      .rst_n     (rst_n),
      .clr       (block_soft_reset_bit),
      .src_rise  (src_rise),
      .load      (start_load),
      .run       (running),
      .reload    (subsecond_reload_reg),
      .half_tick (cal_half)
   );

   rcb_subsec #(.W(SUBSEC_W)) u_tm_pre (
      .clk       (clk),
      .rst_n     (rst_n),
      .clr       (block_soft_reset_bit),
      .src_rise  (src_rise),
      .load      (start_load),
      .run       (running),
      .reload    (subsecond_reload_reg),
      .half_tick (tm_half)
   );

   rcb_timer u_timer (
      .clk       (clk),
      .rst_n     (rst_n),
      .clr       (block_soft_reset_bit),
      .start     (ctrl_wr && wdata[CB_TMST] && !tm_start),
      .stop      (ctrl_wr && !wdata[CB_TMST]),
      .repeat_en (tm_repeat),
      .period    (timer_period_reg),
      .half_tick (tm_half),
      .expire    (tm_expire),
      .active    (tm_active)
   );

   // one-second generation; a second that falls inside a rewrite is held back
   assign one_sec  = cal_half && half_q;                                       // [R11]
   assign sec_tick = running && !rewrite_continue_bit && (one_sec || pend_sec); // [R20]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q         <= 1'b0;
         pend_sec       <= 1'b0;
         half_sec_pulse <= 1'b0;
         alarm_q        <= 1'b0;
      end else begin
         half_sec_pulse <= cal_half;                                           // [R7]
         alarm_q        <= alarm_match;
         if (block_soft_reset_bit || start_load) begin
            half_q   <= 1'b0;
            pend_sec <= 1'b0;
         end else begin
            if (cal_half) begin
               half_q <= ~half_q;                                              // [R11]
            end
            if (rewrite_continue_bit && one_sec) begin
               pend_sec <= 1'b1;                                               // [R20]
            end else if (sec_tick) begin
               pend_sec <= 1'b0;
            end
         end
      end
   end

   function automatic logic [CAL_W-1:0] month_days(input logic [CAL_W-1:0] mon,
                                                   input logic [CAL_W-1:0] yr);
      case (mon)
         MON_FEB:                    month_days = (yr[1:0] == 2'h0) ? DAYS_FEB_LEAP
                                                                    : DAYS_FEB; // [R3]
         7'h04, 7'h06, 7'h09, 7'h0b: month_days = DAYS_SHORT;
         default:                    month_days = DAYS_LONG;
      endcase
   endfunction

   // >= comparisons pull an out-of-range value back into range on the next carry
   always_comb begin
      next_cnt = cal_cnt;
      c_min    = cal_cnt[CAL_SEC] >= SEC_MAX;                                  // [R24]
      c_hour   = c_min && (cal_cnt[CAL_MIN] >= MIN_MAX);
      c_day    = c_hour && (cal_cnt[CAL_HOUR] >= HOUR_MAX);
      c_mon    = c_day && (cal_cnt[CAL_DATE] >=
                           month_days(cal_cnt[CAL_MON], cal_cnt[CAL_YEAR]));
      c_year   = c_mon && (cal_cnt[CAL_MON] >= MON_MAX);
      next_cnt[CAL_SEC] = c_min ? '0 : cal_cnt[CAL_SEC] + 7'h01;              // [R2]
      if (c_min) begin
         next_cnt[CAL_MIN] = c_hour ? '0 : cal_cnt[CAL_MIN] + 7'h01;
      end
      if (c_hour) begin
         next_cnt[CAL_HOUR] = c_day ? '0 : cal_cnt[CAL_HOUR] + 7'h01;
      end
      if (c_day) begin
         next_cnt[CAL_DATE] = c_mon ? DATE_MIN : cal_cnt[CAL_DATE] + 7'h01;
         next_cnt[CAL_WDAY] = (cal_cnt[CAL_WDAY] >= WDAY_MAX) ? '0
                                                              : cal_cnt[CAL_WDAY] + 7'h01;
      end
      if (c_mon) begin
         next_cnt[CAL_MON] = c_year ? MON_MIN : cal_cnt[CAL_MON] + 7'h01;
      end
      if (c_year) begin
         next_cnt[CAL_YEAR] = (cal_cnt[CAL_YEAR] >= YEAR_MAX) ? '0
                                                              : cal_cnt[CAL_YEAR] + 7'h01;
      end
   end

   // counters ignore the soft reset so time survives it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CAL; i++) begin
            cal_cnt[i] <= CAL_RST[i];
         end
      end else begin
         for (int i = 0; i < NUM_CAL; i++) begin
            if (start_load || (rw_xfer && cal_dirty[i])) begin
               cal_cnt[i] <= cal_reg[i];                                       // [R13] [R14]
            end else if (sec_tick) begin
               cal_cnt[i] <= next_cnt[i];                                      // [R11]
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CAL; i++) begin
            cal_reg[i] <= CAL_RST[i];
         end
         cal_dirty <= '0;
      end else begin
         for (int i = 0; i < NUM_CAL; i++) begin
            if (counter_read_request) begin
               cal_reg[i] <= cal_cnt[i];                                       // [R16]
            end else if (wr_en && cal_hit[i]) begin
               cal_reg[i] <= wdata[CAL_W-1:0];
            end
         end
         if (rw_xfer || block_soft_reset_bit) begin
            cal_dirty <= '0;                                                   // [R21]
         end else if (rewrite_continue_bit && wr_en) begin
            cal_dirty <= cal_dirty | cal_hit;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         subsecond_reload_reg <= '0;
         timer_period_reg     <= '0;
         alm_en               <= '0;
         for (int i = 0; i < NUM_ALM; i++) begin
            alm_reg[i] <= '0;
         end
      end else if (block_soft_reset_bit) begin
         alm_en <= '0;
      end else if (wr_en) begin
         if (addr == OFS_RELOAD) begin
            subsecond_reload_reg <= wdata[SUBSEC_W-1:0];
         end
         if (addr == OFS_PERIOD) begin
            timer_period_reg <= (wdata > DATA_W'(DAY_SECONDS)) ? DAY_SECONDS
                                                               : wdata[PERIOD_W-1:0]; // [R6]
         end
         if (addr == OFS_ALM_EN) begin
            alm_en <= wdata[NUM_ALM-1:0];                                      // [R4]
         end
         for (int i = 0; i < NUM_ALM; i++) begin
            if (alm_hit[i]) begin
               alm_reg[i] <= wdata[CAL_W-1:0];
            end
         end
      end
   end

   assign alarm_match = running && (|alm_en) && (&alm_eq);                      // [R4] [R5]

   always_comb begin
      flag_set           = '0;
      flag_set[FL_ALARM] = alarm_match && !alarm_q;                            // [R5]
      flag_set[FL_HOUR]  = sec_tick && c_hour;                                 // [R7]
      flag_set[FL_MIN]   = sec_tick && c_min;
      flag_set[FL_SEC]   = sec_tick;
      flag_set[FL_HALF]  = cal_half;
      flag_set[FL_TIMER] = tm_expire;
      flag_set[FL_RWERR] = rewrite_continue_bit && one_sec && pend_sec;        // [R22]
      flag_set[FL_READ]  = counter_read_request;                               // [R17]
   end

   assign flag_clr = (flags_wr ? wdata[NUM_FLAGS-1:0] : '0)
                     | (rw_xfer ? NUM_FLAGS'(1 << FL_RWERR) : '0);             // [R22]

   // a new event in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_flags <= '0;
      end else if (block_soft_reset_bit) begin
         int_flags <= '0;                                                      // [R1]
      end else begin
         int_flags <= (int_flags & ~flag_clr) | flag_set;                      // [R7]
      end
   end

   always_comb begin
      ctrl_rd            = '0;
      ctrl_rd[CB_START]  = running;
      ctrl_rd[CB_READ]   = counter_read_request;
      ctrl_rd[CB_REWR]   = rewrite_continue_bit;
      ctrl_rd[CB_TMST]   = tm_start;
      ctrl_rd[CB_TMREP]  = tm_repeat;
      ctrl_rd[CB_RUN]    = running;
      ctrl_rd[CB_BUSY]   = busy;
      ctrl_rd[CB_TMRUN]  = tm_active;
   end

   // unmapped addresses read as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= '0;
         if (rd_en) begin
            if (addr == OFS_CTRL) begin
               rdata <= ctrl_rd;
            end
            if (addr == OFS_FLAGS) begin
               rdata <= DATA_W'(int_flags);
            end
            if (addr == OFS_RELOAD) begin
               rdata <= DATA_W'(subsecond_reload_reg);
            end
            if (addr == OFS_PERIOD) begin
               rdata <= DATA_W'(timer_period_reg);
            end
            if (addr == OFS_ALM_EN) begin
               rdata <= DATA_W'(alm_en);
            end
            for (int i = 0; i < NUM_CAL; i++) begin
               if (cal_hit[i]) begin
                  rdata <= DATA_W'(cal_reg[i]);
               end
            end
            for (int i = 0; i < NUM_ALM; i++) begin
               if (alm_hit[i]) begin
                  rdata <= DATA_W'(alm_reg[i]);
               end
            end
         end
      end
   end
endmodule

// file: core/rcb_subsec.sv
`timescale 1ns/10ps
// source clock divide-by-two and sub-second down counter giving half-second ticks
module rcb_subsec
   import rcb_pkg::*;
#(
   parameter int W = SUBSEC_W
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         src_rise,
   input  wire logic         load,
   input  wire logic         run,
   input  wire logic [W-1:0] reload,
   output logic              half_tick
);
   logic         div;
   logic [W-1:0] cnt;

   // period is reload+1 divided source cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div       <= 1'b0;
         cnt       <= '0;
         half_tick <= 1'b0;
      end else begin
         half_tick <= 1'b0;
         if (clr) begin
            div <= 1'b0;
            cnt <= '0;
         end else if (load) begin
            div <= 1'b0;
            cnt <= reload;                       // [R8]
         end else if (run && src_rise) begin
            div <= ~div;                         // [R9]
            if (div) begin
               if (cnt == '0) begin
                  cnt       <= reload;           // [R8]
                  half_tick <= 1'b1;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
         end
      end
   end
endmodule

// file: core/rcb_timer.sv
`timescale 1ns/10ps
// interval timer counting down in half-second steps
module rcb_timer
   import rcb_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                clr,
   input  wire logic                start,
   input  wire logic                stop,
   input  wire logic                repeat_en,
   input  wire logic [PERIOD_W-1:0] period,
   input  wire logic                half_tick,
   output logic                     expire,
   output logic                     active
);
   logic [TIMER_W-1:0] cnt;
   logic [TIMER_W-1:0] load_val;

   // period is in seconds, the counter in half seconds
   assign load_val = {period, 1'b0};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt    <= '0;
         active <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (clr || stop) begin
            active <= 1'b0;
         end else if (start && !active) begin
            cnt    <= load_val;                  // [R10]
            active <= (period != '0);
         end else if (active && half_tick) begin
            if (cnt <= TIMER_W'(1)) begin
               expire <= 1'b1;                   // [R6]
               cnt    <= load_val;
               active <= repeat_en;              // [R6]
            end else begin
               cnt <= cnt - 1'b1;                // [R10]
            end
         end
      end
   end
endmodule

// file: inc/rcb_pkg.sv
// constants shared by the calendar counting block and its sub-modules
package rcb_pkg;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int SUBSEC_W  = 20;
   localparam int PERIOD_W  = 17;
   localparam int TIMER_W   = PERIOD_W + 1;
   localparam int CAL_W     = 7;
   localparam int NUM_CAL   = 7;
   localparam int NUM_ALM   = 5;
   localparam int NUM_FLAGS = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RELOAD   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PERIOD   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CAL_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ALM_BASE = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_ALM_EN   = 8'h40;

   // calendar field index: second, minute, hour, date, month, year, weekday
   localparam int CAL_SEC  = 0;
   localparam int CAL_MIN  = 1;
   localparam int CAL_HOUR = 2;
   localparam int CAL_DATE = 3;
   localparam int CAL_MON  = 4;
   localparam int CAL_YEAR = 5;
   localparam int CAL_WDAY = 6;
   localparam logic [CAL_W-1:0] CAL_RST [NUM_CAL] =
      '{7'h00, 7'h00, 7'h00, 7'h01, 7'h01, 7'h00, 7'h00};

   // control register bits
   localparam int CB_START  = 0;
   localparam int CB_READ   = 1;
   localparam int CB_REWR   = 2;
   localparam int CB_BLOCK_SOFT_RESET_BIT   = 3;
   localparam int CB_TMST   = 4;
   localparam int CB_TMREP  = 5;
   localparam int CB_RUN    = 8;
   localparam int CB_BUSY   = 9;
   localparam int CB_TMRUN  = 10;

   // event flag bits
   localparam int FL_ALARM = 0;
   localparam int FL_HOUR  = 1;
   localparam int FL_MIN   = 2;
   localparam int FL_SEC   = 3;
   localparam int FL_HALF  = 4;
   localparam int FL_TIMER = 5;
   localparam int FL_RWERR = 6;
   localparam int FL_READ  = 7;

   // calendar limits
   localparam logic [CAL_W-1:0] SEC_MAX       = 7'h3b;
   localparam logic [CAL_W-1:0] MIN_MAX       = 7'h3b;
   localparam logic [CAL_W-1:0] HOUR_MAX      = 7'h17;
   localparam logic [CAL_W-1:0] MON_MAX       = 7'h0c;
   localparam logic [CAL_W-1:0] YEAR_MAX      = 7'h63;
   localparam logic [CAL_W-1:0] WDAY_MAX      = 7'h06;
   localparam logic [CAL_W-1:0] DATE_MIN      = 7'h01;
   localparam logic [CAL_W-1:0] MON_MIN       = 7'h01;
   localparam logic [CAL_W-1:0] MON_FEB       = 7'h02;
   localparam logic [CAL_W-1:0] DAYS_LONG     = 7'h1f;
   localparam logic [CAL_W-1:0] DAYS_SHORT    = 7'h1e;
   localparam logic [CAL_W-1:0] DAYS_FEB      = 7'h1c;
   localparam logic [CAL_W-1:0] DAYS_FEB_LEAP = 7'h1d;
   localparam logic [PERIOD_W-1:0] DAY_SECONDS = 17'h15180;
endpackage

// file: verification/rcb_count_block_asserts.sv
// port assertions for the calendar counting block
`timescale 1ns/10ps
module rcb_count_asserts
   import rcb_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [DATA_W-1:0]    wdata,
   input  wire logic                 wr_en,
   input  wire logic                 rd_en,
   input  wire logic [DATA_W-1:0]    rdata,
   input  wire logic [NUM_FLAGS-1:0] int_flags,
   input  wire logic                 half_sec_pulse,
   input  wire logic                 running
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire ctl_wr = wr_en && addr == OFS_CTRL;
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == '0)
      else $error("read data outside answer cycle");
   start_run_a: assert property (ctl_wr |=> running == $past(wdata[CB_START]))
      else $error("running does not follow start");
   half_one_a: assert property (half_sec_pulse |=> !half_sec_pulse)
      else $error("half second pulse too long");
   half_flag_a: assert property (half_sec_pulse |-> ##[0:1] int_flags[FL_HALF])
      else $error("half second flag missing");
   read_done_a: assert property (ctl_wr && wdata[CB_READ] && !wdata[CB_BLOCK_SOFT_RESET_BIT]
      |-> ##2 int_flags[FL_READ])
      else $error("read completion flag late");
   read_keep_a: assert property ($fell(int_flags[FL_READ]) |-> $past(wr_en) || $past(wr_en, 2))
      else $error("read flag dropped without write");
   half_stop_a: assert property (!running [*3] |-> !half_sec_pulse)
      else $error("half pulse while stopped");
   sec_stop_a: assert property (!running [*3] |-> !$rose(int_flags[FL_SEC]))
      else $error("second flag while stopped");
   cover property (ctl_wr && wdata[CB_READ]);
   cover property ($rose(running));
   cover property (half_sec_pulse);
endmodule

// file: verification/tb.sv
// self-checking bench for the calendar counting block
`timescale 1ns/10ps
module tb
   import rcb_pkg::*;
;
   logic                 clk, resetn, src_clk, wr_en, rd_en, rd_d;
   logic [ADDR_W-1:0]    addr;
   logic [DATA_W-1:0]    wdata, rdata;
   logic [NUM_FLAGS-1:0] int_flags;
   logic                 half_sec_pulse, running;
   logic [DATA_W-1:0]    exp_q[$];
   logic [DATA_W-1:0]    setv [NUM_CAL];
   logic [DATA_W-1:0]    expv [NUM_CAL];
   int                   n_errors, compares, wday, av;
   rcb_count_block uut (.clk, .resetn, .rtc_source_clock(src_clk), .addr, .wdata, .wr_en,
      .rd_en, .rdata, .int_flags, .half_sec_pulse, .running);
   always #5 clk = ~clk;
   // odd offset keeps the source clock out of phase with clk
   initial begin
      src_clk = 1'b0;
      #3;
      forever #40 src_clk = ~src_clk;
   end
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic flag(input int i, input logic [DATA_W-1:0] e);
      check(DATA_W'(int_flags[i]), e);
   endtask
   function automatic logic [ADDR_W-1:0] cal_a(input int i);
      return OFS_CAL_BASE + ADDR_W'(4 * i);
   endfunction
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (rd_d) check(rdata, exp_q.pop_front());
      rd_d <= rd_en;
   end
   task automatic print_verdict();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // generous bound, the sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      rd_d = 1'b0;
      addr = '0;
      wdata = '0;
      void'($urandom(76686));
      wday = $urandom % 7;
      av = $urandom % 24;
      setv = '{32'h3a, 32'h3b, 32'h17, 32'h1c, 32'h2, 32'h0, DATA_W'(wday)};
      expv = '{32'h0, 32'h0, 32'h0, 32'h1d, 32'h2, 32'h0, DATA_W'((wday + 1) % 7)};
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_CTRL, 32'h0);
      rd(cal_a(CAL_DATE), 32'h1);
      rd(8'hfc, 32'h0);
      foreach (setv[i]) wr(cal_a(i), setv[i]);
      wr(OFS_RELOAD, 32'h1);
      wr(OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h101);
      // two seconds carry 23:59:58 feb 28 of year 00 into a leap day
      repeat (140) @(posedge clk);
      wr(OFS_CTRL, 32'h3);
      repeat (3) @(posedge clk);
      foreach (expv[i]) rd(cal_a(i), expv[i]);
      rd(OFS_FLAGS, 32'h9e);
      wr(OFS_ALM_BASE + 8'h4, DATA_W'(av));
      rd(OFS_ALM_BASE + 8'h4, DATA_W'(av));
      wr(OFS_ALM_BASE, 32'h0);
      wr(OFS_ALM_EN, 32'h1);
      repeat (3) @(posedge clk);
      flag(FL_ALARM, 32'h1);
      wr(OFS_PERIOD, 32'h1);
      wr(OFS_CTRL, 32'h31);
      repeat (48) @(posedge clk);
      flag(FL_TIMER, 32'h1);
      wr(OFS_FLAGS, 32'h20);
      flag(FL_TIMER, 32'h0);
      rd(OFS_CTRL, 32'h531);
      // the repeating timer expires again one second later
      repeat (54) @(posedge clk);
      flag(FL_TIMER, 32'h1);
      wr(OFS_CTRL, 32'h5);
      rd(OFS_CTRL, 32'h305);
      wr(cal_a(CAL_HOUR), 32'h5);
      repeat (144) @(posedge clk);
      flag(FL_RWERR, 32'h1);
      wr(OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      flag(FL_RWERR, 32'h0);
      wr(OFS_CTRL, 32'h9);
      repeat (3) @(posedge clk);
      check(DATA_W'({running, int_flags}), 32'h0);
      // only the hour written during the rewrite reached the counters
      wr(OFS_CTRL, 32'h2);
      rd(cal_a(CAL_HOUR), 32'h5);
      rd(cal_a(CAL_DATE), 32'h1d);
      // let the last read answer be compared before the run ends
      repeat (2) @(posedge clk);
      print_verdict();
   end
endmodule
bind rcb_count_block rcb_count_asserts chk (.clk, .resetn, .addr, .wdata, .wr_en, .rd_en,
   .rdata, .int_flags, .half_sec_pulse, .running);
